/* hda_top.sv */
// Purpose: peripheral hub arbiter and 24 channel descriptor dma engine
// Assumes: cpu and spoke bus on clk_i; trig_i asynchronous pins
// Notes:   one transaction is one read plus one write of 1 to 4 bytes
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1 - cpu and dma both master the hub
// RULE2 - eight access paths numbered 0 to 7
// RULE3 - different paths let cpu and dma overlap
// RULE4 - transfers of 8, 16, 24, 32 bits
// RULE5 - 24 channels sharing 128 descriptors
// RULE6 - descriptors rewritable live, new values used
// RULE7 - eight priority levels, lower number wins
// RULE8 - trigger by pin, cpu or channel completion
// RULE9 - two interrupt pulses per channel transfer
// RULE10 - channels can be stalled or aborted
// RULE11 - size 1 byte to 64 KB or unbounded
// RULE12 - descriptors chain and may rewrite descriptors
// RULE13 - cpu wins a shared path over dma
// RULE14 - cpu can never starve dma forever
// RULE15 - preemption only between whole transactions
// RULE16 - fairness shares levels 2 to 7 bandwidth
// RULE17 - levels 0 and 1 skip fairness
// RULE18 - equal levels rotate round robin
// RULE19 - round robin off wins its level
// RULE20 - fairness off grants purely by level
// RULE21 - one descriptor moves source to sink
// RULE22 - self linked descriptor repeats forever
// RULE23 - requests held until grant, one per path
module hda_top
  import hda_pkg::*;
(
  // clock, reset, enable
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 ce_i,
  // apb slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // cpu master side of the hub
  input  wire logic                 cpu_req_i,
  input  wire logic [2:0]           cpu_path_i,
  output logic                      cpu_gnt_o,
  // dma master side toward the spokes
  output logic                      bus_req_o,
  output logic                      bus_we_o,
  output logic      [2:0]           bus_path_o,
  output logic      [31:0]          bus_addr_o,
  output logic      [31:0]          bus_wdata_o,
  output logic      [1:0]           bus_size_o,
  input  wire logic                 bus_ack_i,
  input  wire logic [31:0]          bus_rdata_i,
  // triggers and channel interrupts
  input  wire logic [hda_pkg::NCH-1:0] trig_i,
  output logic      [hda_pkg::NCH-1:0] irq_td_o,
  output logic      [hda_pkg::NCH-1:0] irq_end_o
);
  import hda_pkg::*;

  typedef struct packed {
    logic [NCH-1:0]             s1, s2, s3, lvl;
    logic [NCH-1:0]             pend, stall, started;
    logic [NCH-1:0]             ch_en, rr_dis, chain_en;
    logic [NCH-1:0][2:0]        prio;
    logic [NCH-1:0][6:0]        first_td, cur_td;
    logic [NCH-1:0][4:0]        chain_to;
    logic [NCH-1:0][15:0]       offs;
    logic [NTD-1:0][31:0]       src, dst;
    logic [NTD-1:0][15:0]       cnt;
    logic [NTD-1:0][6:0]        nxt_td;
    logic [NTD-1:0][7:0]        flags;
    logic [NLVL-1:0][4:0]       rr_last;
    logic                       fair_en, gen_en;
    logic [4:0]                 fair_cnt;
    logic [3:0]                 starve;
    hda_st_type                 st;
    logic [4:0]                 act;
    logic [31:0]                data;
    logic [2:0]                 cpu_path;
    logic                       cpu_gnt, pready, pslverr;
    logic [31:0]                prdata;
    logic                       bus_req, bus_we;
    logic [2:0]                 bus_path;
    logic [31:0]                bus_addr, bus_wdata;
    logic [1:0]                 bus_size;
    logic [NCH-1:0]             irq_td, irq_end;
  } hda_state_type;

  hda_state_type r_r, r_nxt;

  logic [NCH-1:0] elig, set_v, clr_v;
  logic [NLVL-1:0] any_lvl;
  logic [2:0] best_lvl, win_lvl, fair_lvl;
  logic [4:0] win;
  logic found, start, adv;
  logic [31:0] rd_a, wr_a;

  function automatic hda_state_type td_wr(input hda_state_type s,
      input logic [6:0] t, input logic [1:0] w, input logic [31:0] d);
    hda_state_type o;
    o = s;
    case (w)
      2'h0: o.src[t] = d;
      2'h1: o.dst[t] = d;
      2'h2: o.cnt[t] = d[15:0];
      default: begin
        o.nxt_td[t] = d[6:0];
        o.flags[t] = d[TW_FLAG+:8];
      end
    endcase
    return o;
  endfunction

  function automatic logic path_free(input logic [31:0] a,
      input logic req, input logic [2:0] cp, input logic [3:0] sv);
    // cpu keeps the path unless dma has waited long enough
    return !(req && cp == a[PATH_LSB+:3]) || sv == STARVE_MAX; // [RULE13] [RULE14]
  endfunction

  always_comb begin
    logic [6:0] t;
    logic [11:0] tdo;
    logic [16:0] sum;
    logic [4:0] ch;
    logic [4:0] a;
    int c;
    t = 7'h0;
    tdo = 12'h000;
    sum = 17'h0_0000;
    ch = 5'h00;
    a = r_r.act;
    c = 0;
    r_nxt = r_r;
    set_v = '0;
    clr_v = '0;
    elig = '0;
    any_lvl = '0;
    best_lvl = 3'h7;
    found = 1'b0;
    start = 1'b0;
    adv = 1'b0;
    win = 5'h00;
    // arbitration over pending, enabled, unstalled channels
    for (int i = 0; i < NCH; i++) begin
      elig[i] = r_r.pend[i] & r_r.ch_en[i] & ~r_r.stall[i] & r_r.gen_en; // [RULE10]
      if (elig[i]) begin
        any_lvl[r_r.prio[i]] = 1'b1;
        if (r_r.prio[i] < best_lvl)
          best_lvl = r_r.prio[i]; // [RULE7]
      end
    end
    // lowest clear bit of the slot counter picks the favoured level
    fair_lvl = 3'h7;
    for (int i = 4; i >= 0; i--) begin
      if (!r_r.fair_cnt[i])
        fair_lvl = 3'(i + 2);
    end
    win_lvl = best_lvl; // [RULE20]
    if (r_r.fair_en && best_lvl >= 3'h2 && any_lvl[fair_lvl])
      win_lvl = fair_lvl; // [RULE16] [RULE17]
    for (int i = 1; i <= NCH; i++) begin
      c = (int'(r_r.rr_last[win_lvl]) + i) % NCH;
      if (!found && elig[c] && r_r.prio[c] == win_lvl) begin
        found = 1'b1;
        win = 5'(c); // [RULE18]
      end
    end
    for (int i = NCH - 1; i >= 0; i--) begin
      if (elig[i] && r_r.prio[i] == win_lvl && r_r.rr_dis[i])
        win = 5'(i); // [RULE19]
    end
    t = r_r.cur_td[a];
    rd_a = r_r.src[t] + (r_r.flags[t][TF_SINC] ? 32'(r_r.offs[a]) : '0);
    wr_a = r_r.dst[t] + (r_r.flags[t][TF_DINC] ? 32'(r_r.offs[a]) : '0);
    if (ce_i) begin
      // three stage sync; a level counts once stages two and three agree
      r_nxt.s1 = trig_i;
      r_nxt.s2 = r_r.s1;
      r_nxt.s3 = r_r.s2;
      r_nxt.lvl = (r_r.lvl & (r_r.s2 ^ r_r.s3)) | (r_r.s2 & r_r.s3);
      set_v = r_r.s2 & r_r.s3 & ~r_r.lvl; // [RULE8]
      r_nxt.irq_td = '0;
      r_nxt.irq_end = '0;
      r_nxt.pready = 1'b0;
      r_nxt.pslverr = 1'b0;
      // apb: one wait state, then pready for one cycle
      if (psel_i && penable_i && !r_r.pready) begin
        r_nxt.pready = 1'b1;
        r_nxt.prdata = RST_WORD;
        ch = paddr_i[6:2];
        tdo = paddr_i - OFF_TD;
        if (paddr_i >= OFF_TD && tdo < TD_SPAN) begin
          t = tdo[10:4];
          if (pwrite_i)
            r_nxt = td_wr(r_nxt, t, tdo[3:2], pwdata_i); // [RULE6]
          case (tdo[3:2])
            2'h0: r_nxt.prdata = r_r.src[t];
            2'h1: r_nxt.prdata = r_r.dst[t];
            2'h2: r_nxt.prdata = {16'h0000, r_r.cnt[t]};
            default: r_nxt.prdata = {16'h0000, r_r.flags[t], 1'b0,
                                     r_r.nxt_td[t]};
          endcase
        end else if (paddr_i[11:7] == OFF_CHCFG[11:7] && ch < 5'(NCH)) begin
          if (pwrite_i) begin
            r_nxt.ch_en[ch] = pwdata_i[CFG_EN];
            r_nxt.prio[ch] = pwdata_i[CFG_PRIO+:3]; // [RULE7]
            r_nxt.rr_dis[ch] = pwdata_i[CFG_RRDIS];
            r_nxt.first_td[ch] = pwdata_i[CFG_TD+:7]; // [RULE5]
            r_nxt.chain_to[ch] = pwdata_i[CFG_CHTO+:5];
            r_nxt.chain_en[ch] = pwdata_i[CFG_CHEN];
          end
          r_nxt.prdata = 32'({r_r.chain_en[ch], r_r.chain_to[ch],
                              r_r.first_td[ch], r_r.rr_dis[ch],
                              r_r.prio[ch], r_r.ch_en[ch]});
        end else begin
          case (paddr_i)
            OFF_CTRL: begin
              if (pwrite_i) begin
                r_nxt.fair_en = pwdata_i[CTRL_FAIR];
                r_nxt.gen_en = pwdata_i[CTRL_EN];
              end
              r_nxt.prdata = 32'({r_r.gen_en, r_r.fair_en});
            end
            OFF_STAT: r_nxt.prdata = 32'({r_r.st != ST_IDLE, r_r.act});
            OFF_SWTRIG: begin
              if (pwrite_i && pwdata_i[4:0] < 5'(NCH))
                set_v[pwdata_i[4:0]] = 1'b1; // [RULE8]
            end
            OFF_ABORT: begin
              if (pwrite_i && pwdata_i[4:0] < 5'(NCH))
                clr_v[pwdata_i[4:0]] = 1'b1; // [RULE10]
            end
            OFF_STALL: begin
              if (pwrite_i)
                r_nxt.stall = pwdata_i[NCH-1:0]; // [RULE10]
              r_nxt.prdata = 32'(r_r.stall);
            end
            OFF_PEND: r_nxt.prdata = 32'(r_r.pend);
            default: r_nxt.pslverr = 1'b1;
          endcase
        end
      end
      // engine: a channel switch only happens back in idle
      t = r_r.cur_td[a];
      case (r_r.st)
        ST_IDLE: begin
          if (found) begin
            start = 1'b1;
            r_nxt.act = win; // [RULE15]
            r_nxt.rr_last[win_lvl] = win;
            if (r_r.fair_en && best_lvl >= 3'h2)
              r_nxt.fair_cnt = r_r.fair_cnt + 5'h01;
            r_nxt.st = ST_RDREQ;
          end
        end
        ST_RDREQ: begin
          if (path_free(rd_a, cpu_req_i, cpu_path_i, r_r.starve)) begin
            r_nxt.bus_req = 1'b1; // [RULE21]
            r_nxt.bus_we = 1'b0;
            r_nxt.bus_addr = rd_a;
            r_nxt.bus_path = rd_a[PATH_LSB+:3]; // [RULE2]
            r_nxt.bus_size = r_r.flags[t][TF_W+:2]; // [RULE4]
            r_nxt.starve = 4'h0;
            r_nxt.st = ST_RDACK;
          end else begin
            r_nxt.starve = r_r.starve + 4'h1; // [RULE14]
          end
        end
        ST_RDACK: begin
          if (bus_ack_i) begin
            r_nxt.bus_req = 1'b0;
            r_nxt.data = bus_rdata_i;
            r_nxt.st = ST_WRREQ;
          end
        end
        ST_WRREQ: begin
          if (wr_a[31:16] == TD_WIN) begin
            // nested: this transfer rewrites a descriptor in place
            r_nxt = td_wr(r_nxt, wr_a[10:4], wr_a[3:2], r_r.data); // [RULE12]
            adv = 1'b1;
            r_nxt.st = ST_IDLE;
          end else if (path_free(wr_a, cpu_req_i, cpu_path_i,
                                 r_r.starve)) begin
            r_nxt.bus_req = 1'b1;
            r_nxt.bus_we = 1'b1;
            r_nxt.bus_addr = wr_a;
            r_nxt.bus_path = wr_a[PATH_LSB+:3];
            r_nxt.bus_wdata = r_r.data;
            r_nxt.starve = 4'h0;
            r_nxt.st = ST_WRACK;
          end else begin
            r_nxt.starve = r_r.starve + 4'h1;
          end
        end
        ST_WRACK: begin
          if (bus_ack_i) begin
            r_nxt.bus_req = 1'b0;
            adv = 1'b1;
            r_nxt.st = ST_IDLE;
          end
        end
        default: r_nxt.st = ST_IDLE;
      endcase
      if (adv) begin
        sum = {1'b0, r_r.offs[a]} + 17'(r_r.flags[t][TF_W+:2]) + 17'h0_0001;
        if (!r_r.flags[t][TF_UNB] && sum > {1'b0, r_r.cnt[t]}) begin // [RULE11]
          r_nxt.irq_td[a] = r_r.flags[t][TF_IRQA]; // [RULE9]
          r_nxt.offs[a] = 16'h0000;
          if (r_r.flags[t][TF_LINK]) begin
            r_nxt.cur_td[a] = r_r.nxt_td[t]; // [RULE12] [RULE22]
          end else begin
            clr_v[a] = 1'b1;
            r_nxt.irq_end[a] = r_r.flags[t][TF_IRQB]; // [RULE9]
            if (r_r.chain_en[a] && r_r.chain_to[a] < 5'(NCH))
              set_v[r_r.chain_to[a]] = 1'b1; // [RULE8]
          end
        end else begin
          r_nxt.offs[a] = sum[15:0];
        end
      end
      // a trigger landing with an abort or completion still counts
      for (int i = 0; i < NCH; i++) begin
        if (clr_v[i]) begin
          r_nxt.pend[i] = 1'b0;
          r_nxt.started[i] = 1'b0;
        end
        if (set_v[i]) begin
          r_nxt.pend[i] = 1'b1;
          if (!r_nxt.started[i]) begin
            r_nxt.started[i] = 1'b1;
            r_nxt.cur_td[i] = r_r.first_td[i];
            r_nxt.offs[i] = 16'h0000;
          end
        end
      end
      // the cpu gets every path the dma does not hold next cycle
      r_nxt.cpu_path = cpu_path_i;
      r_nxt.cpu_gnt = cpu_req_i &&
          !(r_nxt.bus_req && r_nxt.bus_path == cpu_path_i); // [RULE1] [RULE3] [RULE23]
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign prdata_o    = r_r.prdata;
  assign pready_o    = r_r.pready;
  assign pslverr_o   = r_r.pslverr;
  assign cpu_gnt_o   = r_r.cpu_gnt;
  assign bus_req_o   = r_r.bus_req;
  assign bus_we_o    = r_r.bus_we;
  assign bus_path_o  = r_r.bus_path;
  assign bus_addr_o  = r_r.bus_addr;
  assign bus_wdata_o = r_r.bus_wdata;
  assign bus_size_o  = r_r.bus_size;
  assign irq_td_o    = r_r.irq_td;
  assign irq_end_o   = r_r.irq_end;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_one_grant_path: assert property ( // [RULE23]
    cpu_gnt_o && bus_req_o |-> r_r.cpu_path != bus_path_o)
    else $error("cpu and dma granted on the same path");
  a_cpu_wins_path: assert property ( // [RULE13]
    ce_i && r_r.st == ST_RDREQ && cpu_req_i &&
    cpu_path_i == rd_a[PATH_LSB+:3] && r_r.starve != STARVE_MAX
    |=> !bus_req_o && r_r.st == ST_RDREQ)
    else $error("dma took a path the cpu requested");
  a_dma_not_starved: assert property ( // [RULE14]
    ce_i && r_r.st == ST_RDREQ && r_r.starve == STARVE_MAX
    |=> bus_req_o && !bus_we_o)
    else $error("dma not issued after starvation limit");
  a_irq_one_pulse: assert property ( // [RULE9]
    ce_i && (|irq_td_o || |irq_end_o) |=> !(|irq_td_o) && !(|irq_end_o))
    else $error("channel interrupt longer than one cycle");
  a_fair_off_prio: assert property ( // [RULE20]
    start && !r_r.fair_en |-> win_lvl == best_lvl)
    else $error("fairness off but level order broken");
  a_high_lvl_excl: assert property ( // [RULE17]
    start && best_lvl < 3'h2 |-> win_lvl == best_lvl)
    else $error("levels 0 or 1 bypassed by fairness");
  a_act_held_xfer: assert property ( // [RULE15]
    r_r.st != ST_IDLE |=> $stable(r_r.act))
    else $error("active channel switched mid transaction");
  a_apb_one_wait: assert property (
    ce_i && psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("apb answer not after one wait state");
endmodule
`default_nettype wire

/* hda_pkg.sv */
// Purpose: shared constants and types of the hub and dma arbiter
// Assumes: apb register port, one clock, byte addresses 12 bits wide
// Notes:   register map, field positions and the engine state type
package hda_pkg;
  localparam int NCH = 24;
  localparam int NTD = 128;
  localparam int NLVL = 8;
  localparam int PATH_LSB = 24;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STAT   = 12'h004;
  localparam logic [11:0] OFF_SWTRIG = 12'h008;
  localparam logic [11:0] OFF_ABORT  = 12'h00C;
  localparam logic [11:0] OFF_STALL  = 12'h010;
  localparam logic [11:0] OFF_PEND   = 12'h014;
  localparam logic [11:0] OFF_CHCFG  = 12'h080;
  localparam logic [11:0] OFF_TD     = 12'h400;
  localparam logic [11:0] TD_SPAN    = 12'h800;
  // control and channel config fields
  localparam int CTRL_FAIR = 0;
  localparam int CTRL_EN   = 1;
  localparam int CFG_EN    = 0;
  localparam int CFG_PRIO  = 1;
  localparam int CFG_RRDIS = 4;
  localparam int CFG_TD    = 5;
  localparam int CFG_CHTO  = 12;
  localparam int CFG_CHEN  = 17;
  // descriptor flag bits, word 3 bits 15:8
  localparam int TF_UNB  = 0;
  localparam int TF_LINK = 1;
  localparam int TF_IRQA = 2;
  localparam int TF_IRQB = 3;
  localparam int TF_SINC = 4;
  localparam int TF_DINC = 5;
  localparam int TF_W    = 6;
  localparam int TW_FLAG = 8;
  // dma writes into this 64 KB window land in the descriptor pool
  localparam logic [15:0] TD_WIN = 16'hF000;
  localparam logic [3:0] STARVE_MAX = 4'h8;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RDREQ, ST_RDACK, ST_WRREQ, ST_WRACK
  } hda_st_type;
endpackage

/* hda_spoke_model.sv */
// Purpose: spoke side memory that answers dma reads and writes
// Assumes: one word per address bits 5:2, full word accesses
// Notes:   slow_i adds three wait cycles before each ack
`timescale 1ns/1ps
`default_nettype none
module hda_spoke_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // dma access from the hub
  input  wire logic        bus_req_i,
  input  wire logic        bus_we_i,
  input  wire logic [31:0] bus_addr_i,
  input  wire logic [31:0] bus_wdata_i,
  input  wire logic        slow_i,
  output logic             bus_ack_o,
  output logic      [31:0] bus_rdata_o
);
  logic [31:0] mem [16];
  logic [1:0]  cnt_r;
  logic [31:0] last_r;
  logic [3:0]  idx;
  assign idx = bus_addr_i[5:2];
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_ack_o   <= 1'b0;
      bus_rdata_o <= 32'h0000_0000;
      cnt_r       <= 2'h0;
      last_r      <= 32'h0000_0000;
      for (int i = 0; i < 16; i++) begin
        mem[i] <= {16'hA5A5, 16'(i)};
      end
    end else begin
      // answer only an open access, once, promptly or after a wait
      if (bus_req_i && !bus_ack_o) begin
        if (!slow_i || cnt_r == 2'h3) begin
          bus_ack_o   <= 1'b1;
          bus_rdata_o <= mem[idx];
          last_r      <= mem[idx];
          cnt_r       <= 2'h0;
        end else begin
          cnt_r       <= cnt_r + 2'h1;
          bus_rdata_o <= ~last_r;
        end
      end else begin
        // released data lines never keep the last value
        bus_ack_o   <= 1'b0;
        bus_rdata_o <= ~last_r;
      end
      if (bus_ack_o && bus_req_i && bus_we_i) begin
        mem[idx] <= bus_wdata_i;
      end
    end
  end
endmodule
`default_nettype wire

/* hda_top_test.sv */
// Purpose: self checking bench for the hub arbiter and dma engine
// Assumes: apb master, spoke model on the dma side, 40 MHz clock
// Notes:   expected data follows the spoke model's reset pattern
`timescale 1ns/1ps
`default_nettype none
module hda_top_test;
  import hda_pkg::*;
  logic clk_i, rstn_i, psel, pen, pwr, cpu_req, slow, ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, baddr, bwdata;
  logic pready, pslverr, cpu_gnt, breq, bwe;
  logic [2:0] cpu_path, bpath;
  logic [1:0] bsize;
  logic [NCH-1:0] trig, irq_td, irq_end;
  int failures, check_count, cycles;
  hda_top u_hda_top (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .cpu_req_i(cpu_req), .cpu_path_i(cpu_path),
    .cpu_gnt_o(cpu_gnt), .bus_req_o(breq), .bus_we_o(bwe),
    .bus_path_o(bpath), .bus_addr_o(baddr), .bus_wdata_o(bwdata),
    .bus_size_o(bsize), .bus_ack_i(ack), .bus_rdata_i(rdata),
    .trig_i(trig), .irq_td_o(irq_td), .irq_end_o(irq_end));
  hda_spoke_model u_hda_spoke_model (.clk_i(clk_i), .rstn_i(rstn_i),
    .bus_req_i(breq), .bus_we_i(bwe), .bus_addr_i(baddr),
    .bus_wdata_i(bwdata), .slow_i(slow), .bus_ack_o(ack),
    .bus_rdata_o(rdata));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, the whole run needs a few hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge clk_i);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic set_td(input int td, input logic [31:0] s,
                        input logic [31:0] d, input logic [31:0] w3);
    logic [11:0] b;
    b = OFF_TD + 12'(td * 16);
    wr(b, s);
    wr(b + 12'h004, d);
    wr(b + 12'h008, 32'h0000_0003);
    wr(b + 12'h00C, w3);
  endtask
  task automatic wait_irq(input int ch, input logic endf, input int lim,
                          output logic hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clk_i);
      #1;
      hit = endf ? irq_end[ch] : irq_td[ch];
    end
  endtask
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    apb(1'b0, OFF_CTRL, 32'h0000_0000, q, e);
    chk32(q, 32'h0000_0000);
    apb(1'b0, OFF_STAT, 32'h0000_0000, q, e);
    chk32(q, 32'h0000_0000);
    apb(1'b0, 12'h300, 32'h0000_0000, q, e);
    chk1(e, 1'b1);
  endtask
  task automatic t_simple();
    logic hit;
    int both;
    both = 0;
    hit = 1'b0;
    set_td(0, 32'h0000_0010, 32'h0000_0020, 32'h0000_C400);
    wr(OFF_CHCFG, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0002);
    cpu_req  <= 1'b1;
    cpu_path <= 3'h3;
    wr(OFF_SWTRIG, 32'h0000_0000);
    for (int i = 0; i < 40 && !hit; i++) begin
      @(posedge clk_i);
      #1;
      if (breq === 1'b1 && cpu_gnt === 1'b1) both++;
      if (breq === 1'b1) chk32({30'h0, bsize}, 32'h0000_0003);
      if (breq === 1'b1) chk32({29'h0, bpath}, 32'h0000_0000);
      hit = irq_td[0];
    end
    cpu_req <= 1'b0;
    chk1(hit, 1'b1);
    chk1(both > 0, 1'b1);
    chk32(u_hda_spoke_model.mem[8], 32'hA5A5_0004);
  endtask
  task automatic t_starve();
    logic hit;
    slow     <= 1'b1;
    cpu_path <= 3'h0;
    cpu_req  <= 1'b1; // held through the whole transfer
    set_td(0, 32'h0000_0014, 32'h0000_0024, 32'h0000_C400);
    #1;
    chk1(cpu_gnt, 1'b1);
    wr(OFF_SWTRIG, 32'h0000_0000);
    wait_irq(0, 1'b0, 80, hit);
    chk1(hit, 1'b1);
    chk32(u_hda_spoke_model.mem[9], 32'hA5A5_0005);
    cpu_req <= 1'b0;
    slow    <= 1'b0;
  endtask
  task automatic t_prio();
    int n;
    set_td(1, 32'h0000_0018, 32'h0000_0028, 32'h0000_C400);
    set_td(2, 32'h0000_001C, 32'h0000_002C, 32'h0000_C400);
    wr(OFF_STALL, 32'h0000_0006);
    wr(OFF_CHCFG + 12'h004, 32'h0000_002B);
    wr(OFF_CHCFG + 12'h008, 32'h0000_0045);
    wr(OFF_SWTRIG, 32'h0000_0001);
    wr(OFF_SWTRIG, 32'h0000_0002);
    wr(OFF_STALL, 32'h0000_0000);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (!(breq === 1'b1 && bwe === 1'b0) && n < 40);
    chk32(baddr, 32'h0000_001C);
    repeat (40) @(posedge clk_i);
    chk32(u_hda_spoke_model.mem[10], 32'hA5A5_0006);
  endtask
  task automatic t_pin();
    logic hit;
    set_td(3, 32'h0000_0030, 32'h0000_0034, 32'h0000_CC00);
    wr(OFF_CHCFG + 12'h00C, 32'h0000_0061);
    trig[3] <= 1'b1;
    wait_irq(3, 1'b1, 40, hit);
    trig[3] <= 1'b0;
    chk1(hit, 1'b1);
    chk32(u_hda_spoke_model.mem[13], 32'hA5A5_000C);
  endtask
  initial begin
    rstn_i = 1'b0;
    {psel, pen, pwr, cpu_req, slow} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cpu_path = 3'h0;
    trig = '0;
    failures = 0;
    check_count = 0;
    cycles = 0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_simple();
    t_starve();
    t_prio();
    t_pin();
    complete_run();
  end
endmodule
`default_nettype wire
